/* logic/ssr_params.svh */
// Constants for the serial shift and storage register block
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

`define SSR_STAGES 8
`define SSR_PINS 5
`define SSR_PIN_DATA 0
`define SSR_PIN_SHCLK 1
`define SSR_PIN_STCLK 2
`define SSR_PIN_SHCLR 3
`define SSR_PIN_STCLR 4
// Clocks reset high so a pin already high gives no false edge
`define SSR_PIN_RST 5'h06
`define SSR_STAGE_RST 8'h00

`endif

/* logic/ssr_pkg.sv */
// Types for the serial shift and storage register block
`include "ssr_params.svh"

package ssr_pkg;
  typedef logic [`SSR_PINS-1:0] ssr_pins_type;
endpackage

/* logic/ssr_shift_storage.sv */
// Serial-in shift chain feeding a parallel storage register
// Operation
// - Eight-stage shift chain feeds separate storage register
// - Shift rise loads serial_in, stages move up
// - Falling shift clock changes nothing
// - Shift clear low forces chain zero, wins
// - Storage rise captures all shift stages
// - Falling storage clock changes nothing
// - Storage clear low zeroes storage register independently
// - Common clock: storage trails chain by one
// - Cascade output carries last shift stage
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_shift_storage
  import ssr_pkg::*;
#(
  parameter int STAGES = `SSR_STAGES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_in,
  input wire logic shift_clock,
  input wire logic storage_clock,
  input wire logic shift_clear_n,
  input wire logic storage_clear_n,
  output logic cascade_out,
  output logic [STAGES-1:0] parallel_out
);

  if (STAGES < 2) begin : g_bad_stages
    $error("STAGES must be at least 2");
  end

  ssr_pins_type pins;
  ssr_pins_type sync1_r, sync2_r, sync3_r, filt_r;
  ssr_pins_type sync1_nxt, sync2_nxt, sync3_nxt, filt_nxt;
  logic [STAGES-1:0] shift_r, shift_nxt, store_r, store_nxt, shift_shifted;
  logic sh_rise, st_rise, sh_clr, st_clr, ser_now;

  assign pins = {storage_clear_n, shift_clear_n, storage_clock, shift_clock, serial_in};

  // Pins are asynchronous; a level counts once stages two and three agree
  always_comb begin
    sync1_nxt = pins;
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
  end

  for (genvar i = 0; i < `SSR_PINS; i++) begin : g_filt
    always_comb begin
      filt_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : filt_r[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= `SSR_PIN_RST;
      sync2_r <= `SSR_PIN_RST;
      sync3_r <= `SSR_PIN_RST;
      filt_r <= `SSR_PIN_RST;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sync3_r <= sync3_nxt;
      filt_r <= filt_nxt;
    end
  end

  // Only rising edges act; falling edges are ignored
  assign sh_rise = filt_nxt[`SSR_PIN_SHCLK] & ~filt_r[`SSR_PIN_SHCLK];
  assign st_rise = filt_nxt[`SSR_PIN_STCLK] & ~filt_r[`SSR_PIN_STCLK];
  assign sh_clr = ~filt_nxt[`SSR_PIN_SHCLR];
  assign st_clr = ~filt_nxt[`SSR_PIN_STCLR];
  // Data goes through the same depth as the clock, keeping setup order
  assign ser_now = filt_nxt[`SSR_PIN_DATA];
  assign shift_shifted = {shift_r[STAGES-2:0], ser_now};

  always_comb begin
    shift_nxt = shift_r;
    if (sh_clr) begin
      shift_nxt = '0;
    end else if (sh_rise) begin
      shift_nxt = shift_shifted;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_r <= STAGES'(`SSR_STAGE_RST);
    end else begin
      shift_r <= shift_nxt;
    end
  end

  always_comb begin
    store_nxt = store_r;
    if (st_clr) begin
      store_nxt = '0;
    end else if (st_rise) begin
      store_nxt = shift_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      store_r <= STAGES'(`SSR_STAGE_RST);
    end else begin
      store_r <= store_nxt;
    end
  end

  assign cascade_out = shift_r[STAGES-1];
  assign parallel_out = store_r;

  // Shifts since last capture, coverage only; saturates
  logic [3:0] shifts_r, shifts_nxt;

  always_comb begin
    shifts_nxt = shifts_r;
    if (!st_clr && st_rise) begin
      shifts_nxt = 4'h0;
    end else if (!sh_clr && sh_rise && shifts_r != 4'hF) begin
      shifts_nxt = shifts_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shifts_r <= 4'h0;
    end else begin
      shifts_r <= shifts_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_shift_clear_zero: assert property (sh_clr |=> shift_r == '0)
    else $error("shift chain not cleared");

  a_shift_clear_pin: assert property ((!shift_clear_n) [*2] |-> ##3 cascade_out == 1'b0)
    else $error("shift clear pin did not empty chain");

  a_shift_load_move: assert property (!sh_clr && sh_rise |=> shift_r == $past(shift_shifted))
    else $error("shift chain did not shift");

  a_shift_pin_rise: assert property ((!shift_clock) [*2] ##1 shift_clock [*2] |-> ##2 sh_rise)
    else $error("shift clock rise missed");

  a_serial_pin_data: assert property ((!shift_clock) [*2] ##1 (shift_clock && shift_clear_n) [*2]
      ##0 $stable(serial_in) |-> ##3 shift_r[0] == $past(serial_in, 3))
    else $error("serial level not loaded into first stage");

  a_shift_fall_hold: assert property (!sh_clr && !sh_rise |=> $stable(shift_r))
    else $error("shift chain changed without rising edge");

  a_shift_pin_fall: assert property (shift_clock [*2] ##1 (!shift_clock) [*2] |-> ##2 !sh_rise)
    else $error("shift clock fall taken as edge");

  a_cascade_last: assert property (!sh_clr && sh_rise |=> cascade_out == $past(shift_r[STAGES-2]))
    else $error("cascade output wrong");

  a_store_clear_zero: assert property (st_clr |=> parallel_out == '0)
    else $error("storage not cleared");

  a_store_clear_pin: assert property ((!storage_clear_n) [*2] |-> ##3 parallel_out == '0)
    else $error("storage clear pin did not empty storage");

  a_store_capture: assert property (!st_clr && st_rise |=> parallel_out == $past(shift_r))
    else $error("storage did not capture chain");

  a_store_pin_rise: assert property ((!storage_clock) [*2] ##1 storage_clock [*2] |-> ##2 st_rise)
    else $error("storage clock rise missed");

  a_store_pin_capture: assert property ((!storage_clock) [*2] ##1 (storage_clock && storage_clear_n) [*2]
      |-> ##3 parallel_out == $past(shift_r))
    else $error("storage clock pin did not capture chain");

  a_shared_edge_lag: assert property (!st_clr && !sh_clr && st_rise && sh_rise
      |=> shift_r == {parallel_out[STAGES-2:0], $past(ser_now)})
    else $error("storage did not trail chain on shared edge");

  a_store_fall_hold: assert property (!st_clr && !st_rise |=> $stable(parallel_out))
    else $error("storage changed without rising edge");

  a_store_pin_fall: assert property (storage_clock [*2] ##1 (!storage_clock) [*2] |-> ##2 !st_rise)
    else $error("storage clock fall taken as edge");

  a_outputs_only_store: assert property (sh_rise && !st_rise && !st_clr |=> $stable(parallel_out))
    else $error("outputs followed shift chain");

  // Main scenarios reached
  c_shift_edge: cover property (!sh_clr && sh_rise);
  c_store_edge: cover property (!st_clr && st_rise);
  c_shared_edge: cover property (!sh_clr && !st_clr && sh_rise && st_rise);
  c_shift_clear: cover property (sh_clr ##1 !sh_clr);
  c_full_byte: cover property (!st_clr && st_rise && shifts_r == 4'(STAGES));

endmodule // ssr_shift_storage

/* bench/ssr_ctl_model.sv */
// Controller model driving serial data and both clocks
`timescale 1ns/1ps

module ssr_ctl_model (
  input wire logic ref_clk,
  output logic serial_in,
  output logic shift_clock,
  output logic storage_clock
);
  initial begin
    serial_in = 1'b0;
    shift_clock = 1'b0;
    storage_clock = 1'b0;
  end
  // Four cycles per level, above the three-cycle pin filter
  task automatic hold();
    repeat (4) @(posedge ref_clk);
  endtask
  // bit first, eight shifts, then strobe in mode 1 only; mode 2 ties clocks
  task automatic send(input logic [7:0] dv, input int m);
    for (int i = 7; i >= 0; i--) begin
      serial_in <= dv[i];
      hold();
      shift_clock <= 1'b1;
      storage_clock <= (m == 2);
      hold();
      shift_clock <= 1'b0;
      storage_clock <= 1'b0;
    end
    hold();
    storage_clock <= (m == 1);
    hold();
    storage_clock <= 1'b0;
    serial_in <= ~serial_in;
    hold();
  endtask
endmodule // ssr_ctl_model

/* bench/tb_serial_shift_storage_register.sv */
// Self-checking bench for the shift and storage register
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %h", $time, a); end end

module tb_serial_shift_storage_register;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic shift_clear_n = 1'b1;
  logic storage_clear_n = 1'b1;
  logic serial_in, shift_clock, storage_clock, cascade_out;
  logic [7:0] parallel_out, chain, held;
  logic [31:0] seed = 32'h59;
  int n_mismatch = 0;
  int total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  ssr_ctl_model ctl (.ref_clk(ref_clk), .serial_in(serial_in), .shift_clock(shift_clock),
    .storage_clock(storage_clock));
  ssr_shift_storage dut (.ref_clk(ref_clk), .rst(rst), .serial_in(serial_in), .shift_clock(shift_clock),
    .storage_clock(storage_clock), .shift_clear_n(shift_clear_n), .storage_clear_n(storage_clear_n),
    .cascade_out(cascade_out), .parallel_out(parallel_out));
  function automatic logic [7:0] exp_out(input int m, input logic [7:0] dv);
    return m == 0 ? held : m == 1 ? dv : {chain[0], dv[7:1]};
  endfunction
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(input int m, input logic [7:0] dv);
    ctl.send(dv, m);
    held = exp_out(m, dv);
    chain = dv;
    `CHK(parallel_out, held)
    `CHK(cascade_out, dv[7])
  endtask
  initial begin
    chain = 8'h00;
    held = 8'h00;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    run(1, 8'hA5);
    shift_clear_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(cascade_out, 1'b0)
    `CHK(parallel_out, 8'hA5)
    // Clear held low through a whole byte must win
    ctl.send(8'hFF, 1);
    `CHK(parallel_out, 8'h00)
    shift_clear_n <= 1'b1;
    chain = 8'h00;
    run(2, 8'h81);
    run(0, 8'hFF);
    storage_clear_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(parallel_out, 8'h00)
    `CHK(cascade_out, 1'b1)
    storage_clear_n <= 1'b1;
    held = 8'h00;
    for (int i = 0; i < 12; i++) begin
      seed = xorshift(seed);
      run(int'(seed[9:8] % 3), seed[7:0]);
    end
    // Mid-run reset empties both registers
    rst <= 1'b1;
    @(posedge ref_clk);
    `CHK(parallel_out, 8'h00)
    `CHK(cascade_out, 1'b0)
    rst <= 1'b0;
    chain = 8'h00;
    held = 8'h00;
    run(1, 8'h3C);
    stop_test();
  end
  // Whole run needs about 1300 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule // tb_serial_shift_storage_register
